// ==== cmpsel_top.sv ====
// comparator input select and edge interrupt register block
`timescale 1ns/1ps
`default_nettype none
module cmpsel_top (
   input  wire logic       sys_clk_i,
   input  wire logic       rstn_i,
   input  wire logic [3:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic      [7:0] rdata_o,
   input  wire logic       cmp_raw_i,
   output logic      [3:0] noninv_route_o,
   output logic      [3:0] inv_route_o,
   output logic            comparator_output_bit_o,
   output logic            irq_o
);
   typedef struct packed {
      cmpsel_pkg::cmpsel_ctrl_t ctrl;
      logic                     output_polarity_select;
      logic                     comparator_irq_flag;
      logic                     irq_mask;
      logic                     out_bit;
      logic                     out_last;
      logic                     out_valid;
      logic [7:0]               rdata;
      logic [3:0]               noninv_route;
      logic [3:0]               inv_route;
      logic                     irq;
   } cmpsel_state_t;

   cmpsel_state_t            st_q;
   cmpsel_state_t            st_d;
   logic                     cmp_level;
   cmpsel_pkg::cmpsel_route_t route;

   // raw analog comparison is asynchronous to the bus clock
   cmpsel_sync u_sync (
      .sys_clk_i (sys_clk_i),
      .rstn_i    (rstn_i),
      .async_i   (cmp_raw_i),
      .level_o   (cmp_level),
      .rise_o    (),
      .fall_o    ()
   );

   cmpsel_route u_route (
      .noninv_input_select_i (st_q.ctrl.noninv_input_select),
      .inv_input_select_i    (st_q.ctrl.inv_input_select),
      .route_o               (route)
   );

   logic ctrl_wr;
   logic stat_wr;
   logic mask_wr;
   logic pol_wr;
   logic rise_ev;
   logic fall_ev;
   logic new_out;
   assign ctrl_wr = wr_i && (addr_i == cmpsel_pkg::CTRL_ADDR);
   assign stat_wr = wr_i && (addr_i == cmpsel_pkg::STATUS_ADDR);
   assign mask_wr = wr_i && (addr_i == cmpsel_pkg::MASK_ADDR);
   assign pol_wr  = wr_i && (addr_i == cmpsel_pkg::POL_ADDR);
   // polarity applied after synchronising so a polarity change is an edge
   assign new_out = cmp_level ^ st_q.output_polarity_select;
   // first sample after reset only primes the edge detector
   assign rise_ev = st_q.out_valid && st_q.out_bit && !st_q.out_last;
   assign fall_ev = st_q.out_valid && !st_q.out_bit && st_q.out_last;

   always_comb begin
      st_d           = st_q;
      st_d.out_last  = st_q.out_bit;
      st_d.out_bit   = new_out;
      st_d.out_valid = 1'b1;
      if (ctrl_wr) begin
         st_d.ctrl = cmpsel_pkg::cmpsel_ctrl_t'(wdata_i
                                               & cmpsel_pkg::CTRL_WMASK);
      end
      if (pol_wr) begin
         st_d.output_polarity_select = wdata_i[0];
      end
      if (mask_wr) begin
         st_d.irq_mask = wdata_i[0];
      end
      if (stat_wr && wdata_i[0]) begin
         st_d.comparator_irq_flag = 1'b0;
      end
      // set beats a simultaneous clear
      if ((rise_ev && st_q.ctrl.rise_edge_irq_en)
          || (fall_ev && st_q.ctrl.fall_edge_irq_en)) begin
         st_d.comparator_irq_flag = 1'b1;
      end
      st_d.rdata = 8'h00;
      if (rd_i) begin
         unique case (addr_i)
            cmpsel_pkg::CTRL_ADDR: begin
               st_d.rdata = st_q.ctrl & cmpsel_pkg::CTRL_WMASK;
            end
            cmpsel_pkg::STATUS_ADDR: begin
               st_d.rdata = {6'h00, st_q.out_bit, st_q.comparator_irq_flag};
            end
            cmpsel_pkg::MASK_ADDR: begin
               st_d.rdata = {7'h00, st_q.irq_mask};
            end
            cmpsel_pkg::POL_ADDR: begin
               st_d.rdata = {7'h00, st_q.output_polarity_select};
            end
            default: begin
               st_d.rdata = 8'h00;
            end
         endcase
      end
      st_d.noninv_route = route.noninv_route;
      st_d.inv_route    = route.inv_route;
      st_d.irq          = st_d.comparator_irq_flag & st_d.irq_mask;
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         st_q      <= '0;
         st_q.ctrl <= cmpsel_pkg::CTRL_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   assign rdata_o                 = st_q.rdata;
   assign noninv_route_o          = st_q.noninv_route;
   assign inv_route_o             = st_q.inv_route;
   assign comparator_output_bit_o = st_q.out_bit;
   assign irq_o                   = st_q.irq;
endmodule // cmpsel_top
`default_nettype wire

// ==== cmpsel_pkg.sv ====
// package for the comparator input select and edge interrupt block
//
// Contract
// - rising output edge sets the interrupt flag only when rise enable is one
// - falling output edge sets the interrupt flag only when fall enable is one
// - noninverting select 11 routes ground, 10 routes fixed voltage reference
// - noninverting select 01 routes dac reference, 00 the external pin
// - inverting select 011, 010, 001 pick negative pins; 110 internal ref
// - output bit is one when plus exceeds minus; inverted polarity reverses
`default_nettype none
package cmpsel_pkg;
   localparam logic [3:0] CTRL_ADDR     = 4'h0;
   localparam logic [3:0] STATUS_ADDR   = 4'h1;
   localparam logic [3:0] MASK_ADDR     = 4'h2;
   localparam logic [3:0] POL_ADDR      = 4'h3;
   localparam int RISE_EN_POS  = 7;
   localparam int FALL_EN_POS  = 6;
   localparam int NSEL_LO      = 4;
   localparam int ISEL_LO      = 0;
   localparam logic [7:0] CTRL_RESET    = 8'h00;
   localparam logic [7:0] CTRL_WMASK    = 8'hF7;
   localparam logic [1:0] NSEL_EXT      = 2'h0;
   localparam logic [1:0] NSEL_DAC      = 2'h1;
   localparam logic [1:0] NSEL_FIXREF   = 2'h2;
   localparam logic [1:0] NSEL_GND      = 2'h3;
   localparam logic [2:0] ISEL_PIN1     = 3'h1;
   localparam logic [2:0] ISEL_PIN2     = 3'h2;
   localparam logic [2:0] ISEL_PIN3     = 3'h3;
   localparam logic [2:0] ISEL_RSV4     = 3'h4;
   localparam logic [2:0] ISEL_RSV5     = 3'h5;
   localparam logic [2:0] ISEL_IREF     = 3'h6;
   typedef struct packed {
      logic       rise_edge_irq_en;
      logic       fall_edge_irq_en;
      logic [1:0] noninv_input_select;
      logic       unused_zero;
      logic [2:0] inv_input_select;
   } cmpsel_ctrl_t;
   // one hot routing of the noninverting input; inverting route is one hot or all zero
   typedef struct packed {
      logic [3:0] noninv_route;
      logic [3:0] inv_route;
   } cmpsel_route_t;
endpackage : cmpsel_pkg
`default_nettype wire

// ==== cmpsel_sync.sv ====
// two flop synchroniser with edge detect on the synchronised level
`timescale 1ns/1ps
`default_nettype none
module cmpsel_sync (
   input  wire logic sys_clk_i,
   input  wire logic rstn_i,
   input  wire logic async_i,
   output logic      level_o,
   output logic      rise_o,
   output logic      fall_o
);
   typedef struct packed {
      logic meta;
      logic sync;
      logic last;
   } cmpsel_sync_t;
   cmpsel_sync_t s_q;
   cmpsel_sync_t s_d;
   always_comb begin
      s_d      = s_q;
      s_d.meta = async_i;
      s_d.sync = s_q.meta;
      s_d.last = s_q.sync;
   end
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign level_o = s_q.sync;
   assign rise_o  = s_q.sync & ~s_q.last;
   assign fall_o  = ~s_q.sync & s_q.last;
endmodule // cmpsel_sync
`default_nettype wire

// ==== cmpsel_route.sv ====
// decode of the two input select fields to one hot routing enables
`timescale 1ns/1ps
`default_nettype none
module cmpsel_route (
   input  wire logic [1:0]              noninv_input_select_i,
   input  wire logic [2:0]              inv_input_select_i,
   output cmpsel_pkg::cmpsel_route_t    route_o
);
   function automatic logic [3:0] dec_noninv(input logic [1:0] s);
      dec_noninv = 4'h0;
      unique case (s)
         cmpsel_pkg::NSEL_GND:    dec_noninv = 4'h8;
         cmpsel_pkg::NSEL_FIXREF: dec_noninv = 4'h4;
         cmpsel_pkg::NSEL_DAC:    dec_noninv = 4'h2;
         cmpsel_pkg::NSEL_EXT:    dec_noninv = 4'h1;
      endcase
   endfunction
   // reserved and zero codes connect nothing rather than guess a source
   function automatic logic [3:0] dec_inv(input logic [2:0] s);
      dec_inv = 4'h0;
      case (s)
         cmpsel_pkg::ISEL_PIN1: dec_inv = 4'h1;
         cmpsel_pkg::ISEL_PIN2: dec_inv = 4'h2;
         cmpsel_pkg::ISEL_PIN3: dec_inv = 4'h4;
         cmpsel_pkg::ISEL_IREF: dec_inv = 4'h8;
         default:               dec_inv = 4'h0;
      endcase
   endfunction
   always_comb begin
      route_o.noninv_route = dec_noninv(noninv_input_select_i);
      route_o.inv_route    = dec_inv(inv_input_select_i);
   end
endmodule // cmpsel_route
`default_nettype wire

// ==== cmpsel_assertions.sv ====
// assertion checker for the comparator select and edge irq block
`timescale 1ns/1ps
`default_nettype none
module cmpsel_assertions (
   input wire logic       sys_clk_i,
   input wire logic       rstn_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic       wr_i,
   input wire logic       rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic [3:0] noninv_route_o,
   input wire logic [3:0] inv_route_o,
   input wire logic       comparator_output_bit_o,
   input wire logic       irq_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);
   logic cw;
   assign cw = wr_i && addr_i == 4'h0;
   a_plus_route: assert property ($past(cw, 2) |->
      noninv_route_o == 4'h1 << $past(wdata_i[5:4], 2)) else $error("plus");
   a_minus_pins: assert property ($past(cw, 2) &&
      $past(wdata_i[2:0], 2) inside {3'h1, 3'h2, 3'h3} |->
      inv_route_o == 4'h1 << ($past(wdata_i[1:0], 2) - 2'h1))
      else $error("pin");
   a_minus_iref: assert property ($past(cw, 2) &&
      $past(wdata_i[2:0], 2) == 3'h6 |-> inv_route_o == 4'h8)
      else $error("iref");
   a_rise_cause: assert property ($rose(irq_o) && !$past(wr_i) &&
      !$past(comparator_output_bit_o, 2) |-> $past(comparator_output_bit_o))
      else $error("rise");
   a_fall_cause: assert property ($rose(irq_o) && !$past(wr_i) &&
      $past(comparator_output_bit_o, 2) |-> !$past(comparator_output_bit_o))
      else $error("fall");
   a_flag_sticky: assert property ($fell(irq_o) |-> $past(wr_i) &&
      $past(addr_i) inside {4'h1, 4'h2}) else $error("sticky");
   a_status_mirror: assert property (rd_i && addr_i == 4'h1 |=>
      rdata_o[1] == $past(comparator_output_bit_o)) else $error("mirror");
   a_bit3_zero: assert property (rd_i && addr_i == 4'h0 |=>
      !rdata_o[3]) else $error("bit3");
endmodule // cmpsel_assertions
bind cmpsel_top cmpsel_assertions u_chk (.sys_clk_i(sys_clk_i),
   .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .rd_i(rd_i), .rdata_o(rdata_o), .noninv_route_o(noninv_route_o),
   .inv_route_o(inv_route_o), .irq_o(irq_o),
   .comparator_output_bit_o(comparator_output_bit_o));
`default_nettype wire

// ==== cmpsel_tb.sv ====
// self-checking bench for the comparator select and edge irq block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic       sys_clk_i, rstn_i, wr_i, rd_i, cmp_raw_i, ob, irq_o;
   logic [3:0] addr_i, nr, ir;
   logic [7:0] wdata_i, rdata_o;
   int         fail_count = 0, checks_done = 0;
   cmpsel_top DUT (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .cmp_raw_i(cmp_raw_i), .noninv_route_o(nr), .inv_route_o(ir),
      .comparator_output_bit_o(ob), .irq_o(irq_o));
   initial begin
      sys_clk_i = 1'b0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end
   task chk(input string n, input logic [7:0] e, g);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
   endtask
   task rd(input logic [3:0] a, input logic [7:0] e, input string n);
      @(posedge sys_clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      #1 chk(n, e, rdata_o);
   endtask
   task t_routes;
      logic [7:0] e;
      for (int p = 0; p < 4; p++) begin
         for (int m = 0; m < 8; m++) begin
            if (m != 4 && m != 5) begin
               wr(4'h0, {2'h0, p[1:0], 1'b1, m[2:0]});
               cyc(2);
               e = (m == 6) ? 8'h08 : 8'h00;
               if (m > 0 && m < 4) begin
                  e = 8'h01 << (m - 1);
               end
               chk("plus route", 8'h01 << p, {4'h0, nr});
               chk("minus route", e, {4'h0, ir});
            end
         end
      end
      rd(4'h0, 8'h37, "ctrl");
      wr(4'hF, 8'hFF);
      rd(4'hF, 8'h00, "unmapped");
   endtask
   task t_irq(input string n, input logic raw, input logic [7:0] e);
      @(posedge sys_clk_i);
      cmp_raw_i <= raw;
      cyc(6);
      chk(n, e, {7'h0, irq_o});
   endtask
   task t_edges;
      wr(4'h2, 8'h01);
      wr(4'h0, 8'h80);
      t_irq("rise on", 1'b1, 8'h01);
      chk("out bit", 8'h01, {7'h0, ob});
      wr(4'h1, 8'h01);
      t_irq("fall off", 1'b0, 8'h00);
      wr(4'h0, 8'h40);
      t_irq("rise off", 1'b1, 8'h00);
      t_irq("fall on", 1'b0, 8'h01);
      wr(4'h2, 8'h00);
      cyc(2);
      chk("masked irq", 8'h00, {7'h0, irq_o});
      rd(4'h1, 8'h01, "sticky flag");
      wr(4'h1, 8'h01);
      rd(4'h1, 8'h00, "cleared flag");
   endtask
   task t_pol;
      wr(4'h3, 8'h01);
      cyc(6);
      chk("out inverted", 8'h01, {7'h0, ob});
      rd(4'h1, 8'h02, "inverted out");
      t_irq("out", 1'b1, 8'h00);
      chk("out raw inverted", 8'h00, {7'h0, ob});
      rd(4'h1, 8'h01, "fall by raw");
   endtask
   task test_done;
      $display("checks %0d errors %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      rstn_i = 1'b0;
      wr_i = 1'b0;
      rd_i = 1'b0;
      cmp_raw_i = 1'b0;
      addr_i = 4'h0;
      wdata_i = 8'h00;
      repeat (16) @(posedge sys_clk_i);
      rstn_i <= 1'b1;
      cyc(3);
      chk("reset plus", 8'h01, {4'h0, nr});
      chk("reset minus", 8'h00, {4'h0, ir});
      chk("reset irq", 8'h00, {7'h0, irq_o});
      chk("reset out", 8'h00, {7'h0, ob});
      chk("reset rdata", 8'h00, rdata_o);
      rd(4'h0, 8'h00, "reset ctrl");
      t_routes;
      t_edges;
      t_pol;
      test_done;
   end
   initial begin
      #200000;
      fail_count++;
      test_done;
   end
endmodule // testbench
`default_nettype wire
